// File: logic/timer16_pwm.sv
// 16-bit timer waveform generator: fast pwm and phase-correct pwm modes
// assumes timer_tick_in is the prescaled timer enable, synchronous to ref_clk_in,
// and that port pin logic outside combines compare_out with the enable here
//
// Overview of operation
// - fast modes count up zero to top
// - fast top fixed, capture or compare a
// - fast: match clears, wrap sets; inverted opposite
// - action two non-inverted, three inverted pwm
// - fast overflow at top, top flag too
// - fixed top masks high compare bits on write
// - capture top written immediately, may overshoot
// - compare a buffered, loaded at top
// - resolution fixed 8/9/10 or variable top
// - compare zero spikes, compare top constant
// - mode 15 toggle gives half-rate square
// - capture top leaves compare a free
// - phase-correct counts up then down
// - phase-correct top source, held one tick
// - phase-correct: up match clears, down sets
// - phase-correct overflow at zero only
// - phase-correct buffers load at top, flag
// - action zero leaves output untouched
// - output state cleared on reset
module timer16_pwm #(
  parameter int CNT_WIDTH = 16,
  parameter int CHANNELS  = 2
) (
  input  wire logic                                   ref_clk_in,
  input  wire logic                                   rstn_in,
  input  wire logic                                   clk_en_in,
  input  wire logic                                   timer_tick_in,
  input  wire logic [timer16_pwm_pkg::ADDR_W-1:0]     addr_in,
  input  wire logic [timer16_pwm_pkg::CNT_W-1:0]      wr_data_in,
  input  wire logic                                   wr_en_in,
  input  wire logic                                   rd_en_in,
  output logic      [timer16_pwm_pkg::CNT_W-1:0]      rd_data_out,
  output logic      [timer16_pwm_pkg::NUM_CH-1:0]     compare_out,
  output logic      [timer16_pwm_pkg::NUM_CH-1:0]     compare_oe_n_out,
  output timer16_pwm_pkg::flags_t                     flags_out
);

  // the logic is written for exactly this width and channel count
  if (CNT_WIDTH != timer16_pwm_pkg::CNT_W || CHANNELS != timer16_pwm_pkg::NUM_CH) begin : g_chk
    $error("timer16_pwm: only 16-bit width and two channels are supported");
  end

  localparam int W = timer16_pwm_pkg::CNT_W;
  localparam int N = timer16_pwm_pkg::NUM_CH;

  // reset release through two flops; assert is asynchronous
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // fixed-top resolution mask, used by both compare writes
  // full width outside the fixed modes, so variable tops keep every bit
  function automatic logic [W-1:0] res_mask(input logic [3:0] m);
    logic [W-1:0] r;
    r = timer16_pwm_pkg::CNT_MAX;
    if (m == timer16_pwm_pkg::MODE_PC_8 || m == timer16_pwm_pkg::MODE_FP_8) begin
      r = timer16_pwm_pkg::TOP_8;
    end else if (m == timer16_pwm_pkg::MODE_PC_9 || m == timer16_pwm_pkg::MODE_FP_9) begin
      r = timer16_pwm_pkg::TOP_9;
    end else if (m == timer16_pwm_pkg::MODE_PC_10 || m == timer16_pwm_pkg::MODE_FP_10) begin
      r = timer16_pwm_pkg::TOP_10;
    end
    return r;
  endfunction

  function automatic logic is_fast(input logic [3:0] m);
    return m == timer16_pwm_pkg::MODE_FP_8 || m == timer16_pwm_pkg::MODE_FP_9 ||
           m == timer16_pwm_pkg::MODE_FP_10 || m == timer16_pwm_pkg::MODE_FP_CAP ||
           m == timer16_pwm_pkg::MODE_FP_CMPA;
  endfunction

  function automatic logic is_phase(input logic [3:0] m);
    return m == timer16_pwm_pkg::MODE_PC_8 || m == timer16_pwm_pkg::MODE_PC_9 ||
           m == timer16_pwm_pkg::MODE_PC_10 || m == timer16_pwm_pkg::MODE_PC_CAP ||
           m == timer16_pwm_pkg::MODE_PC_CMPA;
  endfunction

  // state
  timer16_pwm_pkg::ctrl_t      ctrl_r,  ctrl_nxt;
  timer16_pwm_pkg::flags_t     flags_r, flags_nxt;
  timer16_pwm_pkg::count_dir_t dir_r,   dir_nxt;
  logic [W-1:0]                cnt_r,   cnt_nxt;
  logic [W-1:0]                cap_r,   cap_nxt;
  // buffers take software writes; active copies drive matching and top
  logic [W-1:0]                buf_r    [N];
  logic [W-1:0]                buf_nxt  [N];
  logic [W-1:0]                act_r    [N];
  logic [W-1:0]                act_nxt  [N];
  logic [N-1:0]                oc_r,    oc_nxt;
  logic [N-1:0]                oe_n_r,  oe_n_nxt;
  logic [W-1:0]                rd_r,    rd_nxt;

  // decoded view of the current mode
  logic [3:0]   mode;
  logic         fast;
  logic         phase;
  logic         pwm;
  logic         top_is_cap;
  logic         top_is_cmpa;
  logic [W-1:0] top;
  logic         at_top;
  logic         at_zero;
  logic         up_eff;
  logic         load;
  logic [1:0]   act [N];
  logic [N-1:0] match;

  always_comb begin
    mode        = ctrl_r.waveform_mode_select;
    fast        = is_fast(mode);
    phase       = is_phase(mode);
    pwm         = fast || phase;
    top_is_cap  = mode == timer16_pwm_pkg::MODE_FP_CAP || mode == timer16_pwm_pkg::MODE_PC_CAP;
    top_is_cmpa = mode == timer16_pwm_pkg::MODE_FP_CMPA ||
                  mode == timer16_pwm_pkg::MODE_PC_CMPA;
    // top source: fixed mask, live capture register or active compare a
    if (top_is_cap) begin
      top = cap_r;
    end else if (top_is_cmpa) begin
      top = act_r[timer16_pwm_pkg::CH_A];
    end else if (pwm) begin
      top = res_mask(mode);
    end else begin
      top = timer16_pwm_pkg::CNT_MAX;
    end
    at_top  = cnt_r == top;
    at_zero = cnt_r == timer16_pwm_pkg::CNT_ZERO;
    // at the turning points the slope is the one about to start
    if (at_top) begin
      up_eff = 1'b0;
    end else if (at_zero) begin
      up_eff = 1'b1;
    end else begin
      up_eff = dir_r == timer16_pwm_pkg::DIR_UP;
    end
    act[0] = ctrl_r.compare_a_output_action;
    act[1] = ctrl_r.compare_b_output_action;
    for (int i = 0; i < N; i++) begin
      match[i] = cnt_r == act_r[i];
    end
    // buffer transfer point: counter at top in either pwm family
    load = timer_tick_in && pwm && at_top && (fast || dir_r == timer16_pwm_pkg::DIR_UP);
  end

  // next-state computation for counter, compare units, flags and bus
  always_comb begin
    timer16_pwm_pkg::flags_t set_f;
    timer16_pwm_pkg::flags_t clr_f;
    set_f     = timer16_pwm_pkg::FLAGS_RESET;
    clr_f     = timer16_pwm_pkg::FLAGS_RESET;
    ctrl_nxt  = ctrl_r;
    dir_nxt   = dir_r;
    cnt_nxt   = cnt_r;
    cap_nxt   = cap_r;
    oc_nxt    = oc_r;
    rd_nxt    = timer16_pwm_pkg::CNT_ZERO;
    for (int i = 0; i < N; i++) begin
      buf_nxt[i] = buf_r[i];
      act_nxt[i] = act_r[i];
    end

    // counter sequencing on timer ticks only
    if (timer_tick_in) begin
      if (fast) begin
        if (at_top) begin
          cnt_nxt             = timer16_pwm_pkg::CNT_ZERO;
          set_f.overflow_flag = 1'b1;
        end else begin
          cnt_nxt = cnt_r + timer16_pwm_pkg::CNT_ONE;
        end
      end else if (phase) begin
        if (dir_r == timer16_pwm_pkg::DIR_UP) begin
          if (at_top) begin
            dir_nxt = timer16_pwm_pkg::DIR_DOWN;
            cnt_nxt = cnt_r - timer16_pwm_pkg::CNT_ONE;
          end else begin
            cnt_nxt = cnt_r + timer16_pwm_pkg::CNT_ONE;
          end
        end else if (at_zero) begin
          // bottom is held for one tick too, mirroring the turn at top
          dir_nxt = timer16_pwm_pkg::DIR_UP;
          cnt_nxt = cnt_r + timer16_pwm_pkg::CNT_ONE;
        end else begin
          cnt_nxt = cnt_r - timer16_pwm_pkg::CNT_ONE;
          // flag on arrival at zero, never at top
          set_f.overflow_flag = cnt_r == timer16_pwm_pkg::CNT_ONE;
        end
      end else begin
        // other modes: free-running up count, no waveform action
        cnt_nxt             = cnt_r + timer16_pwm_pkg::CNT_ONE;
        set_f.overflow_flag = cnt_r == timer16_pwm_pkg::CNT_MAX;
      end

      // top-source flag rides with the buffer transfer
      if (load) begin
        set_f.capture_match_flag = top_is_cap;
        set_f.compare_a_flag     = top_is_cmpa;
        for (int i = 0; i < N; i++) begin
          act_nxt[i] = buf_r[i];
        end
      end

      // compare units; a compare left above top by a late top change matches only if an overshooting count passes it
      for (int i = 0; i < N; i++) begin
        if (match[i]) begin
          if (i == 0) begin
            set_f.compare_a_flag = 1'b1;
          end else begin
            set_f.compare_b_flag = 1'b1;
          end
        end
        if (act[i] == timer16_pwm_pkg::ACT_OFF) begin
          oc_nxt[i] = oc_r[i];
        end else if (act[i] == timer16_pwm_pkg::ACT_TOGGLE) begin
          // toggling only where compare a is top; otherwise reserved, no action
          if (i == timer16_pwm_pkg::CH_A && top_is_cmpa && match[i]) begin
            oc_nxt[i] = !oc_r[i];
          end
        end else if (fast) begin
          // wrap after the match so compare equal to top stays constant
          if (match[i]) begin
            oc_nxt[i] = act[i] == timer16_pwm_pkg::ACT_INV;
          end
          if (at_top) begin
            oc_nxt[i] = act[i] == timer16_pwm_pkg::ACT_NONINV;
          end
        end else if (phase && match[i]) begin
          // up-slope match clears for non-inverted, down-slope sets
          oc_nxt[i] = (act[i] == timer16_pwm_pkg::ACT_INV) == up_eff;
        end
      end
    end

    // register writes; a counter write wins over the tick
    if (wr_en_in) begin
      if (addr_in == timer16_pwm_pkg::ADDR_CTRL) begin
        ctrl_nxt      = timer16_pwm_pkg::ctrl_t'(wr_data_in);
        ctrl_nxt.rsvd = '0;
      end else if (addr_in == timer16_pwm_pkg::ADDR_COUNT) begin
        cnt_nxt = wr_data_in;
      end else if (addr_in == timer16_pwm_pkg::ADDR_CMP_A ||
                   addr_in == timer16_pwm_pkg::ADDR_CMP_B) begin
        for (int i = 0; i < N; i++) begin
          if (addr_in == (i == 0 ? timer16_pwm_pkg::ADDR_CMP_A
                                 : timer16_pwm_pkg::ADDR_CMP_B)) begin
            buf_nxt[i] = wr_data_in & res_mask(mode);
            // outside pwm the compare value is not buffered
            if (!pwm) begin
              act_nxt[i] = wr_data_in & res_mask(mode);
            end
          end
        end
      end else if (addr_in == timer16_pwm_pkg::ADDR_CAP_TOP) begin
        cap_nxt = wr_data_in;
      end else if (addr_in == timer16_pwm_pkg::ADDR_FLAGS) begin
        // only ones clear, so writing back a read value drops just what was seen
        clr_f = timer16_pwm_pkg::flags_t'(
                  wr_data_in[$bits(timer16_pwm_pkg::flags_t)-1:0]);
      end
    end
    // a flag event in the clearing cycle survives
    flags_nxt = (flags_r & ~clr_f) | set_f;

    // read data valid only in the cycle after the strobe
    if (rd_en_in) begin
      if (addr_in == timer16_pwm_pkg::ADDR_CTRL) begin
        rd_nxt = ctrl_r;
      end else if (addr_in == timer16_pwm_pkg::ADDR_COUNT) begin
        rd_nxt = cnt_r;
      end else if (addr_in == timer16_pwm_pkg::ADDR_CMP_A) begin
        rd_nxt = buf_r[0];
      end else if (addr_in == timer16_pwm_pkg::ADDR_CMP_B) begin
        rd_nxt = buf_r[1];
      end else if (addr_in == timer16_pwm_pkg::ADDR_CAP_TOP) begin
        rd_nxt = cap_r;
      end else if (addr_in == timer16_pwm_pkg::ADDR_FLAGS) begin
        rd_nxt = W'(flags_r);
      end
    end

    // pin drive needs both the direction bit and a nonzero action
    for (int i = 0; i < N; i++) begin
      oe_n_nxt[i] = !(ctrl_nxt.pin_direction_bit[i] &&
                      (i == 0 ? ctrl_nxt.compare_a_output_action
                              : ctrl_nxt.compare_b_output_action) != timer16_pwm_pkg::ACT_OFF);
    end
  end

  // state registers; clock enable freezes everything
  always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ctrl_r  <= timer16_pwm_pkg::CTRL_RESET;
      flags_r <= timer16_pwm_pkg::FLAGS_RESET;
      dir_r   <= timer16_pwm_pkg::DIR_UP;
      cnt_r   <= timer16_pwm_pkg::CNT_ZERO;
      cap_r   <= timer16_pwm_pkg::CNT_ZERO;
      oc_r    <= '0;
      oe_n_r  <= '1;
      rd_r    <= timer16_pwm_pkg::CNT_ZERO;
      for (int i = 0; i < N; i++) begin
        buf_r[i] <= timer16_pwm_pkg::CNT_ZERO;
        act_r[i] <= timer16_pwm_pkg::CNT_ZERO;
      end
    end else if (clk_en_in) begin
      ctrl_r  <= ctrl_nxt;
      flags_r <= flags_nxt;
      dir_r   <= dir_nxt;
      cnt_r   <= cnt_nxt;
      cap_r   <= cap_nxt;
      oc_r    <= oc_nxt;
      oe_n_r  <= oe_n_nxt;
      rd_r    <= rd_nxt;
      for (int i = 0; i < N; i++) begin
        buf_r[i] <= buf_nxt[i];
        act_r[i] <= act_nxt[i];
      end
    end
  end

  // outputs straight from flops
  assign rd_data_out      = rd_r;
  assign compare_out      = oc_r;
  assign compare_oe_n_out = oe_n_r;
  assign flags_out        = flags_r;

endmodule

// File: logic/timer16_pwm_pkg.sv
// constants, field layouts and types shared by the 16-bit pwm timer block
// assumes a single clock domain and a plain address/strobe register port
package timer16_pwm_pkg;

  // widths
  localparam int CNT_W  = 16;
  localparam int ADDR_W = 3;
  localparam int NUM_CH = 2;
  localparam int CH_A   = 0;

  // waveform_mode_select encodings served here
  localparam logic [3:0] MODE_PC_8    = 4'h1;
  localparam logic [3:0] MODE_PC_9    = 4'h2;
  localparam logic [3:0] MODE_PC_10   = 4'h3;
  localparam logic [3:0] MODE_FP_8    = 4'h5;
  localparam logic [3:0] MODE_FP_9    = 4'h6;
  localparam logic [3:0] MODE_FP_10   = 4'h7;
  localparam logic [3:0] MODE_PC_CAP  = 4'hA;
  localparam logic [3:0] MODE_PC_CMPA = 4'hB;
  localparam logic [3:0] MODE_FP_CAP  = 4'hE;
  localparam logic [3:0] MODE_FP_CMPA = 4'hF;

  // counter values
  localparam logic [15:0] TOP_8    = 16'h00FF;
  localparam logic [15:0] TOP_9    = 16'h01FF;
  localparam logic [15:0] TOP_10   = 16'h03FF;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;

  // compare_output_action encodings
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_NONINV = 2'h2;
  localparam logic [1:0] ACT_INV    = 2'h3;

  // register addresses
  localparam logic [2:0] ADDR_CTRL    = 3'h0;
  localparam logic [2:0] ADDR_COUNT   = 3'h1;
  localparam logic [2:0] ADDR_CMP_A   = 3'h2;
  localparam logic [2:0] ADDR_CMP_B   = 3'h3;
  localparam logic [2:0] ADDR_CAP_TOP = 3'h4;
  localparam logic [2:0] ADDR_FLAGS   = 3'h5;

  // control register layout, reserved bits read zero
  typedef struct packed {
    logic [5:0] rsvd;
    logic [1:0] pin_direction_bit;
    logic [1:0] compare_b_output_action;
    logic [1:0] compare_a_output_action;
    logic [3:0] waveform_mode_select;
  } ctrl_t;

  // status flags, write one to clear
  typedef struct packed {
    logic capture_match_flag;
    logic compare_b_flag;
    logic compare_a_flag;
    logic overflow_flag;
  } flags_t;

  typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;

  localparam ctrl_t  CTRL_RESET  = '0;
  localparam flags_t FLAGS_RESET = '0;

endpackage

// File: verif/timer16_pwm_props.sv
// checker for the pwm timer, watching only its top-level ports
// assumes one clock domain and the register map of the timer package
module timer16_pwm_props #(
  parameter int CNT_WIDTH = 16,
  parameter int CHANNELS  = 2
) (
  input wire logic                               ref_clk_in,
  input wire logic                               rstn_in,
  input wire logic                               clk_en_in,
  input wire logic                               timer_tick_in,
  input wire logic [timer16_pwm_pkg::ADDR_W-1:0] addr_in,
  input wire logic [timer16_pwm_pkg::CNT_W-1:0]  wr_data_in,
  input wire logic                               wr_en_in,
  input wire logic                               rd_en_in,
  input wire logic [timer16_pwm_pkg::CNT_W-1:0]  rd_data_out,
  input wire logic [timer16_pwm_pkg::NUM_CH-1:0] compare_out,
  input wire logic [timer16_pwm_pkg::NUM_CH-1:0] compare_oe_n_out,
  input wire timer16_pwm_pkg::flags_t            flags_out
);
  logic [15:0]            ctrl_r;
  logic [15:0]            ctrl_nxt;
  logic [1:0]             age_r;
  logic [1:0]             age_nxt;
  logic                   ctrl_wr;
  logic                   calm;
  logic                   idle;
  timer16_pwm_pkg::ctrl_t cm;

  // shadow of control; a fresh write makes the config unsettled for two edges
  assign ctrl_wr = clk_en_in && wr_en_in && addr_in == timer16_pwm_pkg::ADDR_CTRL;
  assign calm    = age_r[1] && !ctrl_wr;
  assign idle    = !timer_tick_in || !clk_en_in;
  assign cm      = ctrl_r;
  always_comb begin
    ctrl_nxt = ctrl_wr ? wr_data_in : ctrl_r;
    age_nxt  = ctrl_wr ? 2'h0 : age_r + {1'b0, age_r != 2'h3};
  end
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_r <= 16'h0000;
      age_r  <= 2'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      age_r  <= age_nxt;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);

  property p_reset_clear;
    $rose(rstn_in) |-> compare_out == 2'h0 && flags_out == 4'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear");
  property p_out_hold;
    idle |=> $stable(compare_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output moved w/o tick");
  property p_flag_hold;
    idle |=> (flags_out & ~$past(flags_out)) == 4'h0;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag set w/o tick");
  property p_oe;
    calm |-> compare_oe_n_out == ~{cm.pin_direction_bit[1] && cm.compare_b_output_action != 0,
                                   cm.pin_direction_bit[0] && cm.compare_a_output_action != 0};
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_act_off;
    calm && cm.compare_a_output_action == 2'h0 |=> $stable(compare_out[0]);
  endproperty
  a_act_off: assert property (p_act_off) else $error("idle action moved output");
  property p_fp_cap;
    calm && cm.waveform_mode_select == timer16_pwm_pkg::MODE_FP_CAP && flags_out == 4'h0
      |=> flags_out.overflow_flag == flags_out.capture_match_flag;
  endproperty
  a_fp_cap: assert property (p_fp_cap) else $error("top flags split");
  property p_fp_cmpa;
    calm && cm.waveform_mode_select == timer16_pwm_pkg::MODE_FP_CMPA && flags_out == 4'h0
      |=> flags_out.overflow_flag == flags_out.compare_a_flag;
  endproperty
  a_fp_cmpa: assert property (p_fp_cmpa) else $error("top flags split");
  property p_pc_cap;
    calm && cm.waveform_mode_select == timer16_pwm_pkg::MODE_PC_CAP && flags_out == 4'h0
      |=> !(flags_out.overflow_flag && flags_out.capture_match_flag);
  endproperty
  a_pc_cap: assert property (p_pc_cap) else $error("overflow at top");

  c_toggle: cover property (compare_out[0] != $past(compare_out[0]));
  c_top: cover property (flags_out.overflow_flag && flags_out.capture_match_flag);
  c_pin: cover property (compare_oe_n_out == 2'h2);
endmodule

bind timer16_pwm timer16_pwm_props #(.CNT_WIDTH(CNT_WIDTH), .CHANNELS(CHANNELS)) i_props (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in),
  .timer_tick_in(timer_tick_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
  .compare_out(compare_out), .compare_oe_n_out(compare_oe_n_out), .flags_out(flags_out));

// File: verif/timer16_pwm_tb.sv
// self-checking bench for the pwm timer: register access and tick steps
// assumes the checker file is compiled alongside and binds itself
module timer16_pwm_tb;
  timeunit 1ns;
  timeprecision 100ps;

  `define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end

  logic                    ref_clk = 1'b0;
  logic                    rstn    = 1'b0;
  logic                    clk_en  = 1'b1;
  logic                    tick    = 1'b0;
  logic [2:0]              addr    = 3'h0;
  logic [15:0]             wdata   = 16'h0000;
  logic                    wr      = 1'b0;
  logic                    rd      = 1'b0;
  logic [15:0]             rdata;
  logic [1:0]              cmp_out;
  logic [1:0]              oe_n;
  timer16_pwm_pkg::flags_t flags;
  int                      err_total    = 0;
  int                      total_checks = 0;
  int                      cyc          = 0;
  // per tick: count nibble, output a, flags nibble
  logic [11:0] stp [32] = '{
    12'h100, 12'h202, 12'h302, 12'h01F, 12'h11F, 12'h20F,
    12'h104, 12'h204, 12'h007, 12'h107, 12'h207, 12'h307, 12'h407, 12'h007,
    12'h017, 12'h007, 12'h017, 12'h007,
    12'h104, 12'h206, 12'h306, 12'h20E, 12'h10E, 12'h01F, 12'h11F,
    12'h104, 12'h204, 12'h116, 12'h017, 12'h117, 12'h217, 12'h107};
  logic [3:0]  fix_mode [6] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
  logic [15:0] fix_top [3] = '{timer16_pwm_pkg::TOP_8, timer16_pwm_pkg::TOP_9,
                               timer16_pwm_pkg::TOP_10};

  always #5 ref_clk = ~ref_clk;

  timer16_pwm i_dut (
    .ref_clk_in(ref_clk), .rstn_in(rstn), .clk_en_in(clk_en), .timer_tick_in(tick),
    .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr), .rd_en_in(rd),
    .rd_data_out(rdata), .compare_out(cmp_out), .compare_oe_n_out(oe_n),
    .flags_out(flags));

  task automatic results();
    if (err_total == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard, the whole run needs a few hundred cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  task automatic do_reset();
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd_chk(input string n, input logic [2:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    `CHK(n, e, rdata)
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      tick <= 1'b1;
      @(posedge ref_clk);
      tick <= 1'b0;
    end
    #1;
  endtask

  // one tick per row, then count, output a and flags against the table
  task automatic run(input int lo, input int hi);
    for (int k = lo; k <= hi; k++) begin
      pulse(1);
      rd_chk("count", timer16_pwm_pkg::ADDR_COUNT, {12'h000, stp[k][11:8]});
      `CHK("out a", stp[k][4], cmp_out[0])
      `CHK("flags", stp[k][3:0], flags)
    end
  endtask

  initial begin
    do_reset();
    `CHK("flags", 4'h0, flags)
    `CHK("out", 2'h0, cmp_out)
    `CHK("oe", 2'h3, oe_n)
    wr_reg(timer16_pwm_pkg::ADDR_CTRL, 16'hFFFF);
    rd_chk("ctrl", timer16_pwm_pkg::ADDR_CTRL, 16'h03FF);
    wr_reg(3'h6, 16'h1234);
    rd_chk("unmapped", 3'h6, 16'h0000);
    // fixed tops: masked compares, then one tick taken at top
    for (int i = 0; i < 6; i++) begin
      wr_reg(timer16_pwm_pkg::ADDR_CTRL, {12'h000, fix_mode[i]});
      wr_reg(timer16_pwm_pkg::ADDR_CMP_A, 16'hFFFF);
      rd_chk("mask a", timer16_pwm_pkg::ADDR_CMP_A, fix_top[i % 3]);
      wr_reg(timer16_pwm_pkg::ADDR_CMP_B, 16'hFFFF);
      rd_chk("mask b", timer16_pwm_pkg::ADDR_CMP_B, fix_top[i % 3]);
      wr_reg(timer16_pwm_pkg::ADDR_COUNT, fix_top[i % 3]);
      wr_reg(timer16_pwm_pkg::ADDR_FLAGS, 16'h000F);
      pulse(1);
      rd_chk("at top", timer16_pwm_pkg::ADDR_COUNT,
             i > 2 ? 16'h0000 : fix_top[i % 3] - 16'h0001);
      `CHK("top flag", i > 2, flags.overflow_flag)
    end
    // capture top 3, channel a non-inverted at 1, channel b inverted at top
    do_reset();
    wr_reg(timer16_pwm_pkg::ADDR_CMP_A, 16'h0001);
    wr_reg(timer16_pwm_pkg::ADDR_CMP_B, 16'h0003);
    wr_reg(timer16_pwm_pkg::ADDR_CAP_TOP, 16'h0003);
    wr_reg(timer16_pwm_pkg::ADDR_CTRL, 16'h01EE);
    run(0, 5);
    `CHK("oe", 2'h2, oe_n)
    `CHK("out b", 1'b0, cmp_out[1])
    // capture top below the count overshoots, then takes effect at once
    wr_reg(timer16_pwm_pkg::ADDR_FLAGS, 16'h000F);
    wr_reg(timer16_pwm_pkg::ADDR_COUNT, 16'h0005);
    pulse(1);
    rd_chk("past top", timer16_pwm_pkg::ADDR_COUNT, 16'h0006);
    wr_reg(timer16_pwm_pkg::ADDR_COUNT, 16'hFFFF);
    pulse(1);
    rd_chk("wrap", timer16_pwm_pkg::ADDR_COUNT, 16'h0000);
    `CHK("wrap flag", 1'b0, flags.overflow_flag)
    wr_reg(timer16_pwm_pkg::ADDR_CAP_TOP, 16'h0001);
    pulse(2);
    `CHK("new top", 4'hB, flags)
    `CHK("out a", 1'b1, cmp_out[0])
    // compare a as top: new value waits in the buffer until the top tick
    do_reset();
    wr_reg(timer16_pwm_pkg::ADDR_CMP_A, 16'h0002);
    wr_reg(timer16_pwm_pkg::ADDR_CTRL, 16'h000F);
    wr_reg(timer16_pwm_pkg::ADDR_CMP_A, 16'h0004);
    run(6, 13);
    // toggle on compare a of zero gives a square wave at half the tick rate
    do_reset();
    wr_reg(timer16_pwm_pkg::ADDR_CTRL, 16'h011F);
    run(14, 17);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    pulse(1);
    `CHK("frozen", 1'b0, cmp_out[0])
    @(posedge ref_clk);
    clk_en <= 1'b1;
    pulse(1);
    `CHK("thawed", 1'b1, cmp_out[0])
    // phase-correct with capture top: up, one tick at top, down, bottom
    do_reset();
    wr_reg(timer16_pwm_pkg::ADDR_CMP_A, 16'h0001);
    wr_reg(timer16_pwm_pkg::ADDR_CAP_TOP, 16'h0003);
    wr_reg(timer16_pwm_pkg::ADDR_CTRL, 16'h002A);
    run(18, 24);
    // phase-correct with compare a as top: toggle at each top, overflow at bottom only
    do_reset();
    wr_reg(timer16_pwm_pkg::ADDR_CMP_A, 16'h0002);
    wr_reg(timer16_pwm_pkg::ADDR_CTRL, 16'h001B);
    run(25, 31);
    results();
  end
endmodule
